// File: rtl/card_slot_params.svh
// Register map, field positions and reset values of the paged slot registers.
`ifndef CARD_SLOT_PARAMS_SVH
`define CARD_SLOT_PARAMS_SVH
`define ADDR_SLOT_REG       8'h40
`define ADDR_SECONDARY      8'h42
`define ADDR_PAGE_SELECT    8'h48
`define PAGE_GENERAL        8'h00
`define PAGE_SLOT_FIRST     8'h01
`define PAGE_SLOT_LAST      8'h05
`define PAGE_CLOCK_SLEW     8'h06
`define NUM_SLOTS           5
`define ST_ACTIVE           7
`define ST_EARLY            6
`define ST_MUTE             5
`define ST_OVERLOAD         4
`define ST_SUPPLY           3
`define ST_CLOCK_FALLBACK_FLAG            2
`define ST_PRESENCE_CHANGE_FLAG            1
`define ST_CARD_INSERTED_FLAG             0
`define CT_LOWV             7
`define CT_IOEN             6
`define CT_SEC_HI           5
`define CT_SEC_LO           4
`define CT_LOWPWR           3
`define CT_HIGHV            2
`define CT_WARM             1
`define CT_START            0
`define RST_PAGE_SELECT     8'h00
`define RST_CONTROL         8'h00
`define RST_CFG             8'h4F
`define RST_D               8'hAA
`define RST_CHI             8'hA4
`define RST_CLO             8'h74
`define SEC_CFG             2'h0
`define SEC_D               2'h1
`define SEC_CHI             2'h2
`define SEC_CLO             2'h3
`endif

// File: rtl/card_slot_pkg.sv
// Types shared by the paged slot register bank.
package card_slot_pkg;
  typedef enum logic [1:0] {VSEL_3V, VSEL_5V, VSEL_1V8} supply_sel_e;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_s;
  typedef struct packed {
    logic active;
    logic early;
    logic mute;
    logic overload;
    logic supply_fault;
    logic clock_fallback;
    logic presence_change;
    logic card_inserted;
  } slot_events_s;
endpackage

// File: rtl/card_slot_paged_registers.sv
// Paged register bank: page select, five slot status/control pages, secondary slot registers.
//
// How it works
// - Page-select register at 48h, readable and writable, chooses the secondary page.
// - Page 00h general, 01h-05h slots one to five, 06h clock and slew page.
// - In a slot page, 40h reads slot status and writes slot control.
// - Interrupt output low while any event flag set; released after status read.
// - Supply-fault flag set after power-on until read; interrupt low meanwhile.
// - Status bit 7 reflects whether the selected slot card is active.
// - Status bit 6 set on early answer, cleared after status read.
// - Status bit 5 set on no answer in time, cleared after read.
// - Status bit 4 set on overload or overheating, cleared after read.
// - Status bit 3 set on supervisor fault, cleared after read.
// - Status bit 2 follows the power-down clock fallback state.
// - Status bit 1 set on insertion or extraction, cleared after read.
// - Status bit 0 reflects card presence.
// - Bit 7 selects 1.8 V; else bit 2 selects 5 V or 3 V.
// - Supply-selection bits ignore writes while start is set.
// - Bit 6 connects host I/O to card I/O, else both released.
// - Control bits 5:4 choose the secondary register at 42h.
// - Bit 3 selects low-power clock; locked during start in synchronous mode.
// - Warm reset bit set by write, cleared on start write or mute.
// - Start begins activation only without faults and with card; zero deactivates.
// - Secondary select 00 config, 01 D, 10 C high, 11 C low.
`timescale 1ns/100ps
`include "card_slot_params.svh"

module card_slot_paged_registers
(
  input  wire logic                              clock,
  input  wire logic                              rst_b,
  input  wire card_slot_pkg::host_req_s          host_req,
  input  wire logic [`NUM_SLOTS-1:0]             card_active,
  input  wire logic [`NUM_SLOTS-1:0]             card_present,
  input  wire logic [`NUM_SLOTS-1:0]             clock_fallback,
  input  wire logic [`NUM_SLOTS-1:0]             early_event,
  input  wire logic [`NUM_SLOTS-1:0]             mute_event,
  input  wire logic [`NUM_SLOTS-1:0]             overload_event,
  input  wire logic [`NUM_SLOTS-1:0]             supply_event,
  input  wire logic [`NUM_SLOTS-1:0]             sync_mode,
  input  wire logic                              host_io_line_i,
  input  wire logic [`NUM_SLOTS-1:0]             card_io_i,
  output logic [7:0]                             rdata,
  output logic                                   interrupt_out_n,
  output logic [7:0]                             page_select,
  output logic [`NUM_SLOTS-1:0]                  low_voltage_select,
  output logic [`NUM_SLOTS-1:0]                  high_voltage_select,
  output logic [`NUM_SLOTS-1:0]                  io_connect_enable,
  output logic [`NUM_SLOTS-1:0]                  card_clock_lowpower_select,
  output logic [`NUM_SLOTS-1:0]                  warm_reset,
  output logic [`NUM_SLOTS-1:0]                  start,
  output logic [`NUM_SLOTS-1:0]                  activate_pulse,
  output logic [`NUM_SLOTS-1:0]                  deactivate_pulse,
  output logic                                   host_io_line_o,
  output logic                                   host_io_line_oe_n,
  output logic [`NUM_SLOTS-1:0]                  card_io_o,
  output logic [`NUM_SLOTS-1:0]                  card_io_oe_n
);

  // ==========================================================================
  // Page and address decode
  // ==========================================================================
  logic [7:0]               page_q;
  logic [7:0]               ctrl_q   [`NUM_SLOTS];
  logic [7:0]               sec_q    [`NUM_SLOTS][4];
  logic [`NUM_SLOTS-1:0]    early_q, mute_q, ovl_q, sup_q, presence_change_flag_q;
  logic [`NUM_SLOTS-1:0]    card_inserted_flag_prev_q;
  logic [7:0]               rdata_d;

  wire       page_is_slot = (page_q >= `PAGE_SLOT_FIRST) && (page_q <= `PAGE_SLOT_LAST);
  wire [2:0] slot_idx     = 3'(page_q - `PAGE_SLOT_FIRST);
  wire       wr_page      = host_req.wr && (host_req.addr == `ADDR_PAGE_SELECT);
  wire       rd_page      = host_req.rd && (host_req.addr == `ADDR_PAGE_SELECT);
  wire       wr_ctrl      = host_req.wr && page_is_slot && (host_req.addr == `ADDR_SLOT_REG);
  wire       rd_status    = host_req.rd && page_is_slot && (host_req.addr == `ADDR_SLOT_REG);
  wire       wr_sec       = host_req.wr && page_is_slot && (host_req.addr == `ADDR_SECONDARY);
  wire       rd_sec       = host_req.rd && page_is_slot && (host_req.addr == `ADDR_SECONDARY);

  function automatic logic [1:0] sec_sel(input logic [7:0] c);
    sec_sel = c[`CT_SEC_HI:`CT_SEC_LO];
  endfunction

  function automatic logic [7:0] status_byte(input int unsigned s);
    status_byte = {card_active[s], early_q[s], mute_q[s], ovl_q[s], sup_q[s],
                   clock_fallback[s], presence_change_flag_q[s], card_present[s]};
  endfunction

  wire [7:0] sel_ctrl = ctrl_q[slot_idx];

  // ==========================================================================
  // Read data
  // ==========================================================================
  always_comb
  begin
    rdata_d = 8'h00;
    if (rd_page)
      rdata_d = page_q;
    else if (rd_status)
      rdata_d = status_byte(32'(slot_idx));
    else if (rd_sec)
      rdata_d = sec_q[slot_idx][sec_sel(sel_ctrl)];
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      rdata <= 8'h00;
    else if (host_req.rd)
      rdata <= rdata_d;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      page_q <= `RST_PAGE_SELECT;
    else if (wr_page)
      page_q <= host_req.wdata;
  end

  // ==========================================================================
  // Per-slot flags and control
  // ==========================================================================
  for (genvar s = 0; s < `NUM_SLOTS; s++)
  begin : g_slot
    wire sel      = page_is_slot && (slot_idx == 3'(s));
    wire rd_clr   = rd_status && sel;
    wire wr_this  = wr_ctrl && sel;
    wire card_inserted_flag_chg = card_present[s] != card_inserted_flag_prev_q[s];
    wire [7:0] wd = host_req.wdata;
    wire [7:0] cq = ctrl_q[s];
    wire start_ok = !sup_q[s] && !ovl_q[s] && card_present[s];
    wire lock_sup = cq[`CT_START];
    wire lock_pwr = cq[`CT_START] && sync_mode[s];
    // The host line is copied only while the bridge is not itself driving it.
    wire host_low = !host_io_line_i && host_io_line_oe_n;
    logic [7:0] cd;

    always_comb
    begin
      cd = cq;
      if (wr_this)
      begin
        if (!lock_sup)
        begin
          cd[`CT_LOWV]  = wd[`CT_LOWV];
          cd[`CT_HIGHV] = wd[`CT_HIGHV];
        end
        if (!lock_pwr)
          cd[`CT_LOWPWR] = wd[`CT_LOWPWR];
        cd[`CT_IOEN]   = wd[`CT_IOEN];
        cd[`CT_SEC_HI] = wd[`CT_SEC_HI];
        cd[`CT_SEC_LO] = wd[`CT_SEC_LO];
        cd[`CT_START]  = wd[`CT_START] ? (start_ok || cq[`CT_START]) : 1'b0;
        cd[`CT_WARM]   = wd[`CT_WARM];
        if (wd[`CT_START])
          cd[`CT_WARM] = 1'b0;
      end
      if (mute_q[s] || mute_event[s])
        cd[`CT_WARM] = 1'b0;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
      if (!rst_b)
      begin
        ctrl_q[s]           <= `RST_CONTROL;
        activate_pulse[s]   <= 1'b0;
        deactivate_pulse[s] <= 1'b0;
      end
      else
      begin
        ctrl_q[s]           <= cd;
        activate_pulse[s]   <= wr_this && wd[`CT_START] && start_ok && !cq[`CT_START];
        deactivate_pulse[s] <= wr_this && !wd[`CT_START] && cq[`CT_START];
      end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
      if (!rst_b)
      begin
        early_q[s]     <= 1'b0;
        mute_q[s]      <= 1'b0;
        ovl_q[s]       <= 1'b0;
        sup_q[s]       <= 1'b1;
        presence_change_flag_q[s]     <= 1'b0;
        card_inserted_flag_prev_q[s] <= 1'b0;
      end
      else
      begin
        early_q[s]     <= early_event[s]    || (early_q[s] && !rd_clr);
        mute_q[s]      <= mute_event[s]     || (mute_q[s]  && !rd_clr);
        ovl_q[s]       <= overload_event[s] || (ovl_q[s]   && !rd_clr);
        sup_q[s]       <= supply_event[s]   || (sup_q[s]   && !rd_clr);
        presence_change_flag_q[s]     <= card_inserted_flag_chg          || (presence_change_flag_q[s] && !rd_clr);
        card_inserted_flag_prev_q[s] <= card_present[s];
      end
    end

    for (genvar r = 0; r < 4; r++)
    begin : g_sec
      localparam logic [7:0] RV = (r == 0) ? `RST_CFG : (r == 1) ? `RST_D :
                                  (r == 2) ? `RST_CHI : `RST_CLO;
      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
          sec_q[s][r] <= RV;
        else if (wr_sec && sel && (sec_sel(cq) == 2'(r)))
          sec_q[s][r] <= host_req.wdata;
      end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
      if (!rst_b)
      begin
        low_voltage_select[s]         <= 1'b0;
        high_voltage_select[s]        <= 1'b0;
        io_connect_enable[s]          <= 1'b0;
        card_clock_lowpower_select[s] <= 1'b0;
        warm_reset[s]                 <= 1'b0;
        start[s]                      <= 1'b0;
        card_io_o[s]                  <= 1'b1;
        card_io_oe_n[s]               <= 1'b1;
      end
      else
      begin
        low_voltage_select[s]         <= cd[`CT_LOWV];
        high_voltage_select[s]        <= cd[`CT_HIGHV] && !cd[`CT_LOWV];
        io_connect_enable[s]          <= cd[`CT_IOEN];
        card_clock_lowpower_select[s] <= cd[`CT_LOWPWR];
        warm_reset[s]                 <= cd[`CT_WARM];
        start[s]                      <= cd[`CT_START];
        card_io_o[s]                  <= 1'b0;
        card_io_oe_n[s]               <= !(cd[`CT_IOEN] && host_low);
      end
    end
  end

  // ==========================================================================
  // Host I/O bridge and interrupt
  // ==========================================================================
  // Open-drain style bridge: a low on either side is passed to the other.
  // The host keeps at most one slot connected, so the wired AND needs no arbiter.
  // A low that the bridge drives itself is not passed back, or both sides would latch low.
  wire [`NUM_SLOTS-1:0] card_low = io_connect_enable & ~card_io_i & card_io_oe_n;
  wire any_flag = |(early_q | mute_q | ovl_q | sup_q | presence_change_flag_q);

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      interrupt_out_n   <= 1'b0;
      host_io_line_o    <= 1'b1;
      host_io_line_oe_n <= 1'b1;
      page_select       <= `RST_PAGE_SELECT;
    end
    else
    begin
      interrupt_out_n   <= !any_flag;
      host_io_line_o    <= 1'b0;
      host_io_line_oe_n <= !(|card_low);
      page_select       <= wr_page ? host_req.wdata : page_q;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_status_read;
    rd_status && !early_event[slot_idx] && !mute_event[slot_idx];
  endsequence

  a_flag_clear_read: assert property (@(posedge clock) disable iff (!rst_b)
    s_status_read |=> !early_q[$past(slot_idx)]) else $error("early flag survived read");
  a_event_beats_clear: assert property (@(posedge clock) disable iff (!rst_b)
    rd_status && mute_event[slot_idx] |=> mute_q[$past(slot_idx)])
    else $error("mute event lost on read");
  a_irq_follows_flags: assert property (@(posedge clock) disable iff (!rst_b)
    any_flag |=> !interrupt_out_n) else $error("interrupt not asserted");
  a_irq_release: assert property (@(posedge clock) disable iff (!rst_b)
    !any_flag |=> interrupt_out_n) else $error("interrupt not released");
  a_page_write: assert property (@(posedge clock) disable iff (!rst_b)
    wr_page |=> page_q == $past(host_req.wdata)) else $error("page write lost");
  a_supply_lock: assert property (@(posedge clock) disable iff (!rst_b)
    ctrl_q[0][`CT_START] |=> $stable(low_voltage_select[0])) else $error("supply changed");
  a_low_voltage_wins: assert property (@(posedge clock) disable iff (!rst_b)
    low_voltage_select[0] |-> !high_voltage_select[0]) else $error("both supplies on");
  a_start_guard: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(ctrl_q[0][`CT_START]) |->
      $past(card_present[0]) && !$past(sup_q[0]) && !$past(ovl_q[0]))
    else $error("start without conditions");
  a_warm_cleared: assert property (@(posedge clock) disable iff (!rst_b)
    mute_q[0] |=> !ctrl_q[0][`CT_WARM]) else $error("warm kept after mute");
  a_presence_change: assert property (@(posedge clock) disable iff (!rst_b)
    card_present[0] != card_inserted_flag_prev_q[0] |=> presence_change_flag_q[0]) else $error("presence change missed");

  // ==========================================================================
  // Slot one, page select and host line checks
  // ==========================================================================
  // Slot one stands for all five slots, whose logic is generated from one body.
  sequence s_slot1_read;
    rd_status && (slot_idx == 3'h0);
  endsequence

  a_status_card_inserted_flag_bit: assert property (@(posedge clock) disable iff (!rst_b)
    s_slot1_read |=> rdata[`ST_CARD_INSERTED_FLAG] == $past(card_present[0]))
    else $error("presence bit wrong");
  a_status_active_bit: assert property (@(posedge clock) disable iff (!rst_b)
    s_slot1_read |=> rdata[`ST_ACTIVE] == $past(card_active[0]))
    else $error("active bit wrong");
  a_supply_clear_read: assert property (@(posedge clock) disable iff (!rst_b)
    rd_status && (slot_idx == 3'h0) && !supply_event[0] |=> !sup_q[0])
    else $error("supply flag survived read");
  a_page_readback: assert property (@(posedge clock) disable iff (!rst_b)
    rd_page |=> rdata == $past(page_q))
    else $error("page readback wrong");
  a_off_page_ignored: assert property (@(posedge clock) disable iff (!rst_b)
    host_req.wr && !page_is_slot |=> $stable(start))
    else $error("control changed off a slot page");
  a_highv_lock: assert property (@(posedge clock) disable iff (!rst_b)
    ctrl_q[0][`CT_START] |=> $stable(high_voltage_select[0]))
    else $error("supply level changed during start");
  a_lowpwr_lock: assert property (@(posedge clock) disable iff (!rst_b)
    ctrl_q[0][`CT_START] && sync_mode[0] |=> $stable(card_clock_lowpower_select[0]))
    else $error("low-power clock bit changed during start");
  a_activate_pulse: assert property (@(posedge clock) disable iff (!rst_b)
    activate_pulse[0] |-> start[0] && !$past(start[0]))
    else $error("activation pulse without new start");
  a_deactivate_pulse: assert property (@(posedge clock) disable iff (!rst_b)
    deactivate_pulse[0] |-> !start[0] && $past(start[0]))
    else $error("deactivation pulse without stop");
  a_warm_on_start: assert property (@(posedge clock) disable iff (!rst_b)
    wr_ctrl && (slot_idx == 3'h0) && host_req.wdata[`CT_START] |=> !warm_reset[0])
    else $error("warm reset kept after start write");
  a_sec_write: assert property (@(posedge clock) disable iff (!rst_b)
    wr_sec && (slot_idx == 3'h0) && (sec_sel(ctrl_q[0]) == `SEC_CLO) |=>
      sec_q[0][3] == $past(host_req.wdata))
    else $error("secondary write lost");
  a_io_released: assert property (@(posedge clock) disable iff (!rst_b)
    !io_connect_enable[0] |-> card_io_oe_n[0])
    else $error("card line driven while released");
  a_host_released: assert property (@(posedge clock) disable iff (!rst_b)
    !(|io_connect_enable) |=> host_io_line_oe_n)
    else $error("host line driven with no slot connected");
  a_drive_low_only: assert property (@(posedge clock) disable iff (!rst_b)
    !card_io_oe_n[0] |-> !card_io_o[0])
    else $error("card line driven high");

endmodule

// File: verif/slot_far_model.sv
// Stand-in for the slot sequencers and the pulled-up I/O wires around the register bank.
`timescale 1ns/100ps
module slot_far_model
#(
  parameter int DLY = 3
)
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic [4:0] start,
  input  wire logic [4:0] present_set,
  input  wire logic [1:0] ev_kind,
  input  wire logic       ev_go,
  input  wire logic [4:0] card_io_oe_n,
  input  wire logic       host_oe_n,
  input  wire logic       host_drv_n,
  output logic      [4:0] card_active,
  output logic      [4:0] card_present,
  output logic      [4:0] early_event,
  output logic      [4:0] mute_event,
  output logic      [4:0] overload_event,
  output logic      [4:0] supply_event,
  output logic      [4:0] card_io_i,
  output logic            host_io_line_i
);
  logic [DLY-1:0][4:0] pipe_q;
  // Activation and deactivation take DLY cycles, as a slow sequencer would.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      pipe_q <= '0;
    else
      pipe_q <= {pipe_q[DLY-2:0], start};
  end
  assign card_active    = pipe_q[DLY-1];
  assign card_present   = present_set;
  assign early_event    = {4'h0, ev_go && ev_kind == 2'h0};
  assign mute_event     = {4'h0, ev_go && ev_kind == 2'h1};
  assign overload_event = {4'h0, ev_go && ev_kind == 2'h2};
  assign supply_event   = {4'h0, ev_go && ev_kind == 2'h3};
  // Lines are pulled up: they read low only while some party drives them.
  assign card_io_i      = card_io_oe_n;
  assign host_io_line_i = host_oe_n & host_drv_n;
endmodule

// File: verif/test_card_slot_paged_registers.sv
// Self-checking bench for the paged slot register bank.
`timescale 1ns/100ps
`include "card_slot_params.svh"
module test_card_slot_paged_registers;
  logic clock, rst_b, ev_go, hdrv_n, hio_i, hio_oe_n, irq_n, hio_o;
  card_slot_pkg::host_req_s hreq;
  logic [4:0] act, card_inserted_flag, fb, ea, mu, ov, su, sync, psnt, cio_oe_n, cio_i;
  logic [4:0] lowv, highv, ioen, lpwr, warm, start, actp, deactp, cio_o;
  logic [1:0] ev_kind;
  logic [7:0] rdata, psel;
  int bad_count, tests_run, cyc;
  logic [7:0] sec_rst [4] = '{`RST_CFG, `RST_D, `RST_CHI, `RST_CLO};
  card_slot_paged_registers i_dut (.clock(clock), .rst_b(rst_b), .host_req(hreq),
    .card_active(act), .card_present(card_inserted_flag), .clock_fallback(fb), .early_event(ea),
    .mute_event(mu), .overload_event(ov), .supply_event(su), .sync_mode(sync),
    .host_io_line_i(hio_i), .card_io_i(cio_i), .rdata(rdata), .interrupt_out_n(irq_n),
    .page_select(psel), .low_voltage_select(lowv), .high_voltage_select(highv),
    .io_connect_enable(ioen), .card_clock_lowpower_select(lpwr), .warm_reset(warm),
    .start(start), .activate_pulse(actp), .deactivate_pulse(deactp), .host_io_line_o(hio_o),
    .host_io_line_oe_n(hio_oe_n), .card_io_o(cio_o), .card_io_oe_n(cio_oe_n));
  slot_far_model #(.DLY(3)) i_far (.clock(clock), .rst_b(rst_b), .start(start),
    .present_set(psnt), .ev_kind(ev_kind), .ev_go(ev_go), .card_io_oe_n(cio_oe_n),
    .host_oe_n(hio_oe_n), .host_drv_n(hdrv_n), .card_active(act), .card_present(card_inserted_flag),
    .early_event(ea), .mute_event(mu), .overload_event(ov), .supply_event(su),
    .card_io_i(cio_i), .host_io_line_i(hio_i));
  // ==========================================================
  // Clock, reset and watchdog
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      bad_count++;
      summarize();
    end
  end
  // ==========================================================
  // Access and check tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic access(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #10;
    hreq = '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge clock);
    #10;
    hreq = '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    access(1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    access(1'b1, a, 8'h00);
    check(rdata, exp);
  endtask
  task automatic ev(input logic [1:0] k);
    @(posedge clock);
    #10;
    ev_go = 1'b1;
    ev_kind = k;
    @(posedge clock);
    #10;
    ev_go = 1'b0;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // Test sequence
  initial
  begin
    rst_b = 1'b0;
    hreq = '0;
    {fb, sync, psnt, ev_kind, ev_go} = '0;
    hdrv_n = 1'b1;
    wait_n(4);
    rst_b = 1'b1;
    check({7'h0, irq_n}, 8'h00);
    rd(`ADDR_PAGE_SELECT, 8'h00);
    wr(`ADDR_PAGE_SELECT, `PAGE_CLOCK_SLEW);
    wr(`ADDR_SLOT_REG, 8'hC5);
    check({3'h0, lowv | highv | ioen | start}, 8'h00);
    rd(`ADDR_SLOT_REG, 8'h00);
    $display("test pages done");
    for (int s = 1; s <= 5; s++)
    begin
      wr(`ADDR_PAGE_SELECT, 8'(s));
      rd(`ADDR_PAGE_SELECT, 8'(s));
      check(psel, 8'(s));
      check({7'h0, irq_n}, 8'h00);
      rd(`ADDR_SLOT_REG, 8'h08);
    end
    wait_n(2);
    check({7'h0, irq_n}, 8'h01);
    rd(`ADDR_SLOT_REG, 8'h00);
    $display("test power-on flags done");
    wr(`ADDR_PAGE_SELECT, 8'h01);
    wr(`ADDR_SLOT_REG, 8'h01);
    check({3'h0, start | actp}, 8'h00);
    psnt = 5'h01;
    wait_n(3);
    check({7'h0, irq_n}, 8'h00);
    rd(`ADDR_SLOT_REG, 8'h03);
    rd(`ADDR_SLOT_REG, 8'h01);
    for (int k = 0; k < 4; k++)
    begin
      ev(2'(k));
      wait_n(2);
      check({7'h0, irq_n}, 8'h00);
      wr(`ADDR_SLOT_REG, 8'h00);
      wr(`ADDR_SLOT_REG, 8'h01);
      check({3'h0, start}, k >= 2 ? 8'h00 : 8'h01);
      wr(`ADDR_SLOT_REG, 8'h00);
      wait_n(3);
      rd(`ADDR_SLOT_REG, 8'h01 | (8'h40 >> k));
      rd(`ADDR_SLOT_REG, 8'h01);
    end
    @(posedge clock);
    #10;
    hreq = '{rd: 1'b1, wr: 1'b0, addr: `ADDR_SLOT_REG, wdata: 8'h00};
    {ev_go, ev_kind} = 3'h5;
    @(posedge clock);
    #10;
    hreq = '0;
    ev_go = 1'b0;
    rd(`ADDR_SLOT_REG, 8'h21);
    $display("test flags done");
    wr(`ADDR_SLOT_REG, 8'h84);
    check({3'h0, lowv}, 8'h01);
    check({3'h0, highv}, 8'h00);
    wr(`ADDR_SLOT_REG, 8'h04);
    check({3'h0, lowv ^ highv}, 8'h01);
    wr(`ADDR_SLOT_REG, 8'h05);
    check({3'h0, start & actp}, 8'h01);
    wait_n(4);
    rd(`ADDR_SLOT_REG, 8'h81);
    wr(`ADDR_SLOT_REG, 8'h81);
    check({2'h0, lowv, actp[0]}, 8'h00);
    sync = 5'h01;
    wr(`ADDR_SLOT_REG, 8'h0D);
    check({3'h0, lpwr}, 8'h00);
    sync = 5'h00;
    wr(`ADDR_SLOT_REG, 8'h0D);
    check({3'h0, lpwr}, 8'h01);
    wr(`ADDR_SLOT_REG, 8'h04);
    check({2'h0, start, deactp[0]}, 8'h01);
    wr(`ADDR_SLOT_REG, 8'h06);
    check({3'h0, warm}, 8'h01);
    wr(`ADDR_SLOT_REG, 8'h07);
    check({2'h0, warm, start[0]}, 8'h01);
    wr(`ADDR_SLOT_REG, 8'h06);
    ev(2'h1);
    wait_n(5);
    check({3'h0, warm}, 8'h00);
    rd(`ADDR_SLOT_REG, 8'h21);
    fb = 5'h01;
    wait_n(2);
    rd(`ADDR_SLOT_REG, 8'h05);
    fb = 5'h00;
    wait_n(2);
    rd(`ADDR_SLOT_REG, 8'h01);
    $display("test control done");
    for (int k = 0; k < 4; k++)
    begin
      wr(`ADDR_SLOT_REG, 8'(k << 4));
      rd(`ADDR_SECONDARY, sec_rst[k]);
    end
    wr(`ADDR_SECONDARY, 8'h5A);
    rd(`ADDR_SECONDARY, 8'h5A);
    wr(`ADDR_SLOT_REG, 8'h00);
    rd(`ADDR_SECONDARY, `RST_CFG);
    $display("test secondary done");
    hdrv_n = 1'b0;
    wait_n(3);
    check({3'h0, cio_oe_n}, 8'h1F);
    wr(`ADDR_SLOT_REG, 8'h40);
    wait_n(3);
    check({6'h0, ioen[0], cio_oe_n[0]}, 8'h02);
    hdrv_n = 1'b1;
    wait_n(3);
    check({4'h0, hio_oe_n, cio_oe_n[0], hio_o, cio_o[0]}, 8'h0C);
    // Slot one, the only slot connected, is released again and no slot stays connected.
    wr(`ADDR_SLOT_REG, 8'h00);
    check({3'h0, ioen}, 8'h00);
    $display("test io done");
    summarize();
  end
endmodule
